//--- rtl/memory_map_address_decoder.v
`timescale 1ns/1ps
`include "memory_map_address_decoder_map.vh"

// Overview of operation
// (R1) Small variant: ROM at 2800-3FFF
// (R2) Large variant: ROM at 2000-3FFF
// (R3) Special subroutine page at 3F00-3FFF
// (R4) Reset and interrupt vectors at 3FF4-3FFF
// (R5) Zero page covers 0000-00FF
// (R6) Small variant RAM: 0000-007F, 0100-013F
// (R7) Large variant RAM: 0000-007F, 0100-017F
// (R8) Stack only in zero-page RAM; outside it stackFault blocks the RAM write but not ioWriteEn
// (R9) Peripheral registers in zero page, outside RAM
// (R10) Reset held low over two microseconds
// (R11) ROM writes ignored; unmapped reads stable
module memory_map_address_decoder
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // Variant strap: 0 small, 1 large
  input  wire        largeVariant,
  // CPU access
  input  wire [15:0] cpuAddr,
  input  wire        cpuRead,
  input  wire        cpuWrite,
  input  wire        stackAccess,
  // Data returned by memories
  input  wire [7:0]  romData,
  input  wire [7:0]  ramData,
  input  wire [7:0]  ioData,
  // Selects, combinational
  output wire        romSel,
  output wire        ramSel,
  output wire        ramWriteEn,
  output wire        ioSel,
  output wire        ioWriteEn,
  // Status
  output wire        specialPage,
  output wire        vectorFetch,
  output wire        zeroPage,
  output wire        stackFault,
  output wire        resetValid,
  // Registered results
  output wire [2:0]  regionCode,
  output wire [7:0]  readData
);

  // Classifier hits
  wire       romHit;
  wire       specialHit;
  wire       vectorHit;
  wire       zeroPageHit;
  wire       ramHit;
  wire       stackHit;
  wire       ioHit;
  // Any read or write
  wire       access;
  // Strap and reset length
  reg        largeVar_ff;
  reg  [6:0] rstCount_ff;
  reg  [6:0] nxt_rstCount;
  reg        resetValid_ff;
  // Registered results and their next values
  reg  [2:0] regionCode_ff;
  reg  [2:0] nxt_regionCode;
  reg  [7:0] readData_ff;
  reg  [7:0] nxt_readData;

  // Classify against the variant latched at reset release. The classifier
  // is purely combinational, so the selects settle in the access cycle.
  region_classify uClassify
  (
    .largeVariant (largeVar_ff),
    .addr         (cpuAddr),
    .romHit       (romHit),
    .specialHit   (specialHit),
    .vectorHit    (vectorHit),
    .zeroPageHit  (zeroPageHit),
    .ramHit       (ramHit),
    .stackHit     (stackHit),
    .ioHit        (ioHit)
  );

  // A cycle is an access when either strobe is up
  assign access = cpuRead || cpuWrite;

  // Strobes, combinational so the memories see them in the access cycle.
  // ROM has no write path at all: a write to ROM space selects nothing.
  assign romSel      = romHit && cpuRead;               // [R11]
  assign ramSel      = ramHit && access;                // [R6] [R7]
  assign ramWriteEn  = ramHit && cpuWrite && !stackFault;
  assign ioSel       = ioHit && access;                 // [R9]
  assign ioWriteEn   = ioHit && cpuWrite;               // [R9]
  assign specialPage = specialHit;                      // [R3]
  assign vectorFetch = vectorHit && cpuRead;            // [R4]
  assign zeroPage    = zeroPageHit;                     // [R5]
  // Stack traffic outside zero-page RAM is flagged and its RAM write blocked (ioWriteEn is not gated);
  // page one holds program data, and a stray push there would corrupt it
  assign stackFault  = stackAccess && access && !stackHit; // [R8]
  // Registered results go straight to the ports
  assign resetValid  = resetValid_ff;
  assign regionCode  = regionCode_ff;
  assign readData    = readData_ff;

  // Strap sampled while reset is low so it is stable after release.
  // A strap change in run time is ignored until the next reset, so the
  // map never shifts under code that is already executing.
  always @(posedge ref_clk)
  begin
    if (!rstn)
      largeVar_ff <= largeVariant;
  end

  // Count reset low time; short glitches never mark a valid reset.
  // The count is cleared only while rstn is high, so after power-up it is
  // unknown until the first release; resetValid is trustworthy only once
  // a release has been followed by a reset that is long enough.
  // The count saturates, so a very long reset cannot wrap it to zero.
  always @*
  begin
    nxt_rstCount = rstCount_ff;
    if (rstCount_ff != 7'h7F)
      nxt_rstCount = rstCount_ff + 7'h01;
  end

  // Count while reset is low, clear once it is released. The flag is
  // sticky: it records that one long enough reset has been seen, and a
  // later short glitch does not take it back.
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rstCount_ff <= nxt_rstCount;
      if (nxt_rstCount >= `RESET_MIN_CYC)
        resetValid_ff <= 1'b1;                          // [R10]
    end
    else
    begin
      rstCount_ff <= 7'h00;
    end
  end

  // Priority encoder for the region code. The vector area lies inside the
  // special page and that page inside ROM, so the narrowest region wins.
  function [2:0] regionOf;
    input vecIn;
    input spcIn;
    input romIn;
    input ramIn;
    input ioIn;
    begin
      regionOf = `REG_NONE;
      if (vecIn)
        regionOf = `REG_VECTOR;                         // [R4]
      else if (spcIn)
        regionOf = `REG_SPECIAL;                        // [R3]
      else if (romIn)
        regionOf = `REG_ROM;
      else if (ramIn)
        regionOf = `REG_RAM;
      else if (ioIn)
        regionOf = `REG_IO;                             // [R9]
    end
  endfunction

  // Read source select; holes give one fixed value, so unmapped reads
  // are stable and touch no memory
  function [7:0] readOf;
    input       romIn;
    input       ramIn;
    input       ioIn;
    input [7:0] romByte;
    input [7:0] ramByte;
    input [7:0] ioByte;
    begin
      if (romIn)
        readOf = romByte;
      else if (ramIn)
        readOf = ramByte;
      else if (ioIn)
        readOf = ioByte;
      else
        readOf = `OPEN_BUS_DATA;                        // [R11]
    end
  endfunction

  // Region code follows the address every cycle, strobes or not, so it
  // also shows where an idle bus points
  always @*
  begin
    nxt_regionCode = regionOf(vectorHit, specialHit, romHit, ramHit, ioHit);
  end

  // Read data moves only on a read; writes and idle cycles hold it, so a
  // write never disturbs what the CPU last read
  always @*
  begin
    nxt_readData = readData_ff;
    if (cpuRead)
      nxt_readData = readOf(romHit, ramHit, ioHit, romData, ramData, ioData);
  end

  // Region code register
  always @(posedge ref_clk)
  begin
    if (!rstn)
      regionCode_ff <= `REG_NONE;
    else
      regionCode_ff <= nxt_regionCode;
  end

  // Read data register
  always @(posedge ref_clk)
  begin
    if (!rstn)
      readData_ff <= `READ_DATA_RST;
    else
      readData_ff <= nxt_readData;
  end

endmodule

//--- rtl/memory_map_address_decoder_map.vh
`ifndef MEMORY_MAP_ADDRESS_DECODER_MAP_VH
`define MEMORY_MAP_ADDRESS_DECODER_MAP_VH

// Region bounds of the memory map
`define ROM_SMALL_LO    16'h2800
`define ROM_LARGE_LO    16'h2000
`define ROM_HI          16'h3FFF
`define SPECIAL_LO      16'h3F00
`define VECTOR_LO       16'h3FF4
`define ZERO_PAGE_HI    16'h00FF
`define RAM0_HI         16'h007F
`define RAM1_LO         16'h0100
`define RAM1_SMALL_HI   16'h013F
`define RAM1_LARGE_HI   16'h017F
`define STACK_LO        16'h0000
`define STACK_HI        16'h007F

// Region codes reported on regionCode
`define REG_NONE        3'h0
`define REG_RAM         3'h1
`define REG_IO          3'h2
`define REG_ROM         3'h3
`define REG_SPECIAL     3'h4
`define REG_VECTOR      3'h5

// Undefined read value for unmapped addresses
`define OPEN_BUS_DATA   8'hFF

// Read data register value while reset is low
`define READ_DATA_RST   8'h00

// Minimum reset low time in ns and in 25 ns clock cycles (rounded up)
`define RESET_MIN_NS    2000
`define CLK_PERIOD_NS   25
`define RESET_MIN_CYC   ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/region_classify.v
`timescale 1ns/1ps
`include "memory_map_address_decoder_map.vh"

// Pure combinational classification of one address
module region_classify
(
  // Variant and address
  input  wire        largeVariant,
  input  wire [15:0] addr,
  // Region hits
  output wire        romHit,
  output wire        specialHit,
  output wire        vectorHit,
  output wire        zeroPageHit,
  output wire        ramHit,
  output wire        stackHit,
  output wire        ioHit
);

  wire [15:0] romLo;
  wire [15:0] ram1Hi;

  // Variant picks ROM base and page-one RAM top
  assign romLo  = largeVariant ? `ROM_LARGE_LO : `ROM_SMALL_LO;  // [R1] [R2]
  assign ram1Hi = largeVariant ? `RAM1_LARGE_HI : `RAM1_SMALL_HI; // [R6] [R7]

  assign romHit      = (addr >= romLo) && (addr <= `ROM_HI);         // [R1] [R2]
  assign specialHit  = (addr >= `SPECIAL_LO) && (addr <= `ROM_HI);   // [R3]
  assign vectorHit   = (addr >= `VECTOR_LO) && (addr <= `ROM_HI);    // [R4]
  assign zeroPageHit = (addr <= `ZERO_PAGE_HI);                      // [R5]
  assign ramHit      = (addr <= `RAM0_HI) ||
                       ((addr >= `RAM1_LO) && (addr <= ram1Hi));     // [R6] [R7]
  // Stack window starts at address zero, so only its top bound is compared
  assign stackHit    = (addr <= `STACK_HI);                          // [R8]
  // Peripheral registers live in zero page above the RAM
  assign ioHit       = zeroPageHit && !(addr <= `RAM0_HI);           // [R9]

endmodule

//--- bench/memory_map_address_decoder_sva.sv
`timescale 1ns/1ps
// Decoder checks; one clock domain, so clocking and reset are given once
module memory_map_address_decoder_sva
(
  // Clock, reset and strap
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        largeVariant,
  // CPU access
  input wire logic [15:0] cpuAddr,
  input wire logic        cpuRead,
  input wire logic        cpuWrite,
  input wire logic        stackAccess,
  input wire logic [7:0]  romData,
  // Decoder outputs
  input wire logic        romSel,
  input wire logic        ramSel,
  input wire logic        ramWriteEn,
  input wire logic        ioSel,
  input wire logic        ioWriteEn,
  input wire logic        specialPage,
  input wire logic        vectorFetch,
  input wire logic        zeroPage,
  input wire logic        stackFault,
  input wire logic [7:0]  readData
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire acc = cpuRead | cpuWrite;
  // ROM low bound moves with the strap, top is fixed
  property p_rom; romSel == (cpuRead && cpuAddr <= 16'h3FFF
    && cpuAddr >= (largeVariant ? 16'h2000 : 16'h2800)); endproperty
  a_rom: assert property (p_rom) else $error("rom select");
  property p_page; specialPage == (cpuAddr[15:8] == 8'h3F) && vectorFetch
    == (cpuRead && cpuAddr >= 16'h3FF4 && cpuAddr <= 16'h3FFF); endproperty
  a_page: assert property (p_page) else $error("page flags");
  property p_zp; zeroPage == (cpuAddr <= 16'h00FF); endproperty
  a_zp: assert property (p_zp) else $error("zero page");
  property p_ram; ramSel == (acc && (cpuAddr <= 16'h007F || cpuAddr >= 16'h0100
    && cpuAddr <= (largeVariant ? 16'h017F : 16'h013F))); endproperty
  a_ram: assert property (p_ram) else $error("ram select");
  property p_stk; stackAccess && cpuWrite && cpuAddr > 16'h007F
    |-> stackFault && !ramWriteEn; endproperty
  a_stk: assert property (p_stk) else $error("stack outside");
  property p_io; ioSel == (acc && cpuAddr >= 16'h0080 && cpuAddr <= 16'h00FF); endproperty
  a_io: assert property (p_io) else $error("io select");
  property p_iow; ioWriteEn == (cpuWrite && cpuAddr >= 16'h0080
    && cpuAddr <= 16'h00FF); endproperty
  a_iow: assert property (p_iow) else $error("io write");
  sequence s_romRead; cpuRead && romSel; endsequence
  property p_rdat; s_romRead |=> readData == $past(romData); endproperty
  a_rdat: assert property (p_rdat) else $error("rom data");
  property p_open; cpuRead && !romSel && !ramSel && !ioSel |=> readData == 8'hFF; endproperty
  a_open: assert property (p_open) else $error("open read");
endmodule
bind memory_map_address_decoder memory_map_address_decoder_sva chk_u (.*);

//--- bench/bus_side_model.sv
`timescale 1ns/1ps
// Memory contents behind the decoder: each byte is a pattern of its address
module bus_side_model
(
  // Address from the CPU
  input  wire logic [15:0] cpuAddr,
  // Data back, same cycle
  output logic      [7:0]  romData,
  output logic      [7:0]  ramData,
  output logic      [7:0]  ioData
);
  // Distinct patterns so a wrong read mux shows up
  assign romData = cpuAddr[7:0] ^ 8'h5A;
  assign ramData = cpuAddr[7:0] ^ 8'hA5;
  assign ioData  = ~cpuAddr[7:0];
endmodule

//--- bench/memory_map_address_decoder_test.sv
`timescale 1ns/1ps
module memory_map_address_decoder_test;
  logic        ref_clk = 0, rstn = 0, largeVariant = 0, cpuRead = 0, cpuWrite = 0;
  logic        stackAccess = 0, romSel, ramSel, ramWriteEn, ioSel, ioWriteEn;
  logic        specialPage, vectorFetch, zeroPage, stackFault, resetValid;
  logic [15:0] cpuAddr = 16'h0000;
  logic [7:0]  romData, ramData, ioData, readData;
  logic [2:0]  regionCode;
  int          bad_count = 0, n_tests = 0;
  memory_map_address_decoder dut_u (.*);
  bus_side_model mem_u (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // One access; c is {read,write,stack}, s is {rom,ram,ramWr,io,fault}, r region code
  task automatic acc(input logic [15:0] a, input logic [2:0] c, input logic [4:0] s,
                     input logic [7:0] d, input logic [2:0] r);
    @(posedge ref_clk);
    {cpuRead, cpuWrite, stackAccess} <= c;
    cpuAddr <= a;
    #1 chk({3'h0, romSel, ramSel, ramWriteEn, ioSel, stackFault}, {3'h0, s});
    chk({7'h0, ioWriteEn}, {7'h0, s[1] & c[1]});
    @(posedge ref_clk);
    #1 chk({5'h0, regionCode}, {5'h0, r});
    if (c[2]) chk(readData, d);
  endtask
  // Strap only settles in reset, so each variant gets a full reset
  task automatic rs(input logic lv);
    @(posedge ref_clk);
    rstn <= 0;
    largeVariant <= lv;
    {cpuRead, cpuWrite, stackAccess} <= 3'h0;
    repeat (81) @(posedge ref_clk);
    rstn <= 1;
    #1 chk({7'h0, resetValid}, 8'h01);
  endtask
  task automatic t_small;
    rs(0);
    acc(16'h2800, 3'h4, 5'h10, 8'h5A, 3'h3);
    acc(16'h27FF, 3'h4, 5'h00, 8'hFF, 3'h0);
    acc(16'h013F, 3'h4, 5'h08, 8'h9A, 3'h1);
    acc(16'h0140, 3'h4, 5'h00, 8'hFF, 3'h0);
    $display("small variant done");
  endtask
  task automatic t_large;
    rs(1);
    acc(16'h2000, 3'h4, 5'h10, 8'h5A, 3'h3);
    acc(16'h3F00, 3'h4, 5'h10, 8'h5A, 3'h4);
    acc(16'h3FF4, 3'h4, 5'h10, 8'hAE, 3'h5);
    acc(16'h017F, 3'h4, 5'h08, 8'hDA, 3'h1);
    acc(16'h00FF, 3'h4, 5'h02, 8'h00, 3'h2);
    acc(16'h0080, 3'h2, 5'h02, 8'h00, 3'h2);
    acc(16'h007F, 3'h3, 5'h0C, 8'h00, 3'h1);
    acc(16'h0100, 3'h3, 5'h09, 8'h00, 3'h1);
    acc(16'h3000, 3'h2, 5'h00, 8'h00, 3'h3);
    $display("large variant done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #100000;
    bad_count++;
    conclude;
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1;
    t_small;
    t_large;
    conclude;
  end
endmodule
